// >>> design/dio_defines.svh
/*
 * Register offsets, field positions, reset values and timing constants of the discrete I/O block.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

`define DIO_OFS_IN_CFG     12'h000
`define DIO_OFS_IN_LEVEL   12'h004
`define DIO_OFS_OUT_CFG    12'h008
`define DIO_OFS_OUT_USER   12'h00C
`define DIO_OFS_STATUS_IN  12'h010
`define DIO_OFS_NRM_CFG0   12'h020
`define DIO_OFS_ERR_CFG0   12'h040
`define DIO_OFS_DUR0       12'h060
`define DIO_OFS_REF0       12'h080
`define DIO_OFS_EPC_LEN    12'h0A0
`define DIO_OFS_IRQ_STAT   12'h0A4
`define DIO_OFS_IRQ_MASK   12'h0A8
`define DIO_OFS_OUT_LEVEL  12'h0AC

`define DIO_PORT_STRIDE    12'h004
`define DIO_NRM_OP_MSB     2
`define DIO_NRM_EN_BIT     3
`define DIO_NRM_CNT_LSB    16
`define DIO_OCFG_MODE_MSB  1
`define DIO_OCFG_SEL_LSB   2
`define DIO_OCFG_SEL_MSB   4
`define DIO_OCFG_W         5
`define DIO_OCFG_STRIDE    8
`define DIO_EPC_LEN_MAX    6'h20
`define DIO_EPC_LEN_AUTO   6'h00
`define DIO_DUR_UNIT_US    100
`define DIO_DUR_UNIT_CYC   ((`DIO_DUR_UNIT_US * 1000) / 100)
`define DIO_IRQ_TRIG_LSB   0
`define DIO_IRQ_START_BIT  4
`define DIO_IRQ_NRM_LSB    5
`define DIO_IRQ_ERR_LSB    9
`define DIO_IRQ_W          13

`endif

// >>> design/dio_pkg.sv
/*
 * Types shared by the discrete I/O block: output modes, status selections, comparison operators, states.
 * Assumes dio_defines.svh is on the include path.
 */
package dio_pkg;

	typedef enum logic [1:0] {
		OUT_USER   = 2'h0,
		OUT_STATUS = 2'h1,
		OUT_RESULT = 2'h2
	} out_mode_t;

	typedef enum logic [2:0] {
		SEL_RUN  = 3'h0,
		SEL_ERR  = 3'h1,
		SEL_ANY  = 3'h2,
		SEL_ANT1 = 3'h4,
		SEL_ANT2 = 3'h5,
		SEL_ANT3 = 3'h6,
		SEL_ANT4 = 3'h7
	} stat_sel_t;

	typedef enum logic [2:0] {
		CMP_GE   = 3'h0,
		CMP_LE   = 3'h1,
		CMP_EQ   = 3'h2,
		CMP_NE   = 3'h3,
		CMP_DEQ  = 3'h4,
		CMP_DNE  = 3'h5
	} cmp_op_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_HOLD  = 2'h1
	} pulse_st_t;

	typedef struct packed {
		logic        valid;
		logic        ok;
		logic [15:0] tag_count;
		logic [31:0] data;
		logic [7:0]  err_code;
	} comm_result_t;

	typedef struct packed {
		logic       running;
		logic       fault;
		logic [3:0] ant_active;
		logic [1:0] ant_sel;
	} reader_status_t;

endpackage : dio_pkg

// >>> design/dio_self_op.sv
/*
 * Discrete I/O and self-operation logic of the reader: four inputs, four programmable outputs,
 * command-series launch requests and timed judgment pulses, all configured over APB.
 * Assumes inputs are synchronous-enough levels from the pins, a command engine that takes the
 * launch pulses, and a tag engine that reports one result per completed communication.
 */
// The APB slave port and the register addresses were decided locally.
`include "dio_defines.svh"

// Contract
// - Each of four inputs is independently a readable input or a command trigger.
// - A readable input reports its present level whenever the host reads it.
// - A trigger input launches its stored command series on a rising edge.
// - Startup and each input have their own stored series slot.
// - Startup series runs at power-up and on each host network connection.
// - Each of four outputs is host-driven, status, or result output.
// - A host-driven output shows the last level the host commanded.
// - Running status output is steady while the reader runs normally.
// - Fault status output is steady while the reader is abnormally stopped.
// - Any-antenna status output is the OR of four antenna activities.
// - Antenna-select output n is high while antenna n is the chosen one.
// - A result output drives its judgment once a tag response returns.
// - Each output has two judgments, each with its own hold duration.
// - Normal judgment compares tag count or read data against configured reference.
// - Error judgment fires when abnormal end code equals configured code.
// - EPC length zero selects auto detection, one to thirty-two fixed.
module dio_self_op #(
	parameter int NPORT  = 4,
	parameter int DUR_W  = 16
) (
	// Clock and reset
	input  wire logic                    CLK,
	input  wire logic                    SYS_RST,
	// APB slave
	input  wire logic                    PSEL,
	input  wire logic                    PENABLE,
	input  wire logic                    PWRITE,
	input  wire logic [11:0]             PADDR,
	input  wire logic [31:0]             PWDATA,
	output logic      [31:0]             PRDATA,
	output logic                         PREADY,
	output logic                         PSLVERR,
	// Discrete pins
	input  wire logic [NPORT-1:0]        DIN,
	output logic      [NPORT-1:0]        DOUT,
	// Reader state and tag engine
	input  wire dio_pkg::reader_status_t RDR_STATUS,
	input  wire dio_pkg::comm_result_t   COMM_RESULT,
	input  wire logic                    HOST_CONNECT,
	// Command series launch requests, one-cycle pulses, and the EPC length setting
	output logic                         RUN_STARTUP,
	output logic      [NPORT-1:0]        RUN_INPUT,
	output logic      [5:0]              EPC_LEN,
	output logic                         EPC_AUTO,
	// Interrupt
	output logic                         IRQ
);

	// Two durations share one register word, so a duration wider than half a word cannot be stored.
	generate
		if (NPORT != 4) begin : g_bad_nport
			$error("dio_self_op supports exactly four ports");
		end
		if (DUR_W < 1 || DUR_W > 16) begin : g_bad_dur_w
			$error("dio_self_op DUR_W out of range");
		end
	endgenerate

	localparam int DUR_CYC = `DIO_DUR_UNIT_CYC;

	// Per-port settings live in small arrays indexed by port number.
	logic [NPORT-1:0]          sync1_r;
	logic [NPORT-1:0]          sync2_r;
	logic [NPORT-1:0]          prev_r;
	logic [NPORT-1:0]          in_cfg_r;
	logic [NPORT-1:0]          user_out_r;
	logic [4:0]                out_cfg_r [NPORT];
	logic [31:0]               nrm_cfg_r [NPORT];
	logic [7:0]                err_cfg_r [NPORT];
	logic [2*DUR_W-1:0]        dur_r     [NPORT];
	logic [31:0]               ref_r     [NPORT];
	logic [5:0]                epc_len_r;
	logic [`DIO_IRQ_W-1:0]     irq_stat_r;
	logic [`DIO_IRQ_W-1:0]     irq_mask_r;
	logic                      boot_r;
	logic                      conn_prev_r;
	logic [NPORT-1:0]          dout_r;
	logic [NPORT-1:0]          edge_hit;
	logic                      startup_hit;
	logic [NPORT-1:0]          nrm_hit;
	logic [NPORT-1:0]          err_hit;
	logic [NPORT-1:0]          pulse_lvl;
	logic [NPORT-1:0]          stat_lvl;
	logic [`DIO_IRQ_W-1:0]     irq_set;
	logic                      wr_en;
	logic                      rd_en;
	logic [31:0]               rd_data;
	logic                      rd_ok;
	logic                      rd_stat;

	// Decodes the per-port register index from an address inside a four-word bank.
	function automatic logic [1:0] port_idx(input logic [11:0] addr, input logic [11:0] base);
		logic [11:0] ofs;
		ofs = addr - base;
		port_idx = ofs[3:2];
	endfunction : port_idx

	// True when the address falls inside a bank of four consecutive words.
	function automatic logic in_bank(input logic [11:0] addr, input logic [11:0] base);
		in_bank = (addr >= base) && (addr < base + (`DIO_PORT_STRIDE << 2));
	endfunction : in_bank

	// Status source selection for a status-mode output.
	// Antenna select codes zero to three stand for antennas one to four.
	function automatic logic status_level(input logic [2:0] sel, input dio_pkg::reader_status_t st);
		case (dio_pkg::stat_sel_t'(sel))
			dio_pkg::SEL_RUN:  status_level = st.running;
			dio_pkg::SEL_ERR:  status_level = st.fault;
			dio_pkg::SEL_ANY:  status_level = |st.ant_active;
			dio_pkg::SEL_ANT1: status_level = (st.ant_sel == 2'h0);
			dio_pkg::SEL_ANT2: status_level = (st.ant_sel == 2'h1);
			dio_pkg::SEL_ANT3: status_level = (st.ant_sel == 2'h2);
			dio_pkg::SEL_ANT4: status_level = (st.ant_sel == 2'h3);
			default:           status_level = 1'b0;
		endcase
	endfunction : status_level

	// Normal-completion comparison: field [2:0] operator, [3] enable, [31:16] compared count.
	function automatic logic normal_match(input logic [31:0] cfg, input logic [31:0] refd,
		input dio_pkg::comm_result_t r);
		logic [15:0] num;
		num = cfg[31:`DIO_NRM_CNT_LSB];
		case (dio_pkg::cmp_op_t'(cfg[`DIO_NRM_OP_MSB:0]))
			dio_pkg::CMP_GE:  normal_match = r.tag_count >= num;
			dio_pkg::CMP_LE:  normal_match = r.tag_count <= num;
			dio_pkg::CMP_EQ:  normal_match = r.tag_count == num;
			dio_pkg::CMP_NE:  normal_match = r.tag_count != num;
			dio_pkg::CMP_DEQ: normal_match = r.data == refd;
			dio_pkg::CMP_DNE: normal_match = r.data != refd;
			default:          normal_match = 1'b0;
		endcase
	endfunction : normal_match

	// The slave never stretches a transfer, so every access completes in its first access cycle.
	assign wr_en   = PSEL && PENABLE && PWRITE;
	assign rd_en   = PSEL && PENABLE && !PWRITE;
	assign PREADY  = 1'b1;

	// Only the second stage feeds edge detection so a metastable first stage never fans out.
	// The edge memory resets to the idle low level, so a line held low through reset gives no false edge.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= DIN;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign edge_hit = sync2_r & ~prev_r & in_cfg_r;

	// Startup fires once after reset and on each rising edge of the host connection level.
	// A host that drops and re-establishes its connection launches the startup series again.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			boot_r      <= 1'b1;
			conn_prev_r <= 1'b0;
		end else begin
			boot_r      <= 1'b0;
			conn_prev_r <= HOST_CONNECT;
		end
	end

	assign startup_hit = boot_r || (HOST_CONNECT && !conn_prev_r);

	// Launch requests are registered so the command engine sees clean one-cycle pulses.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RUN_STARTUP <= 1'b0;
			RUN_INPUT   <= '0;
		end else begin
			RUN_STARTUP <= startup_hit;
			RUN_INPUT   <= edge_hit;
		end
	end

	// Register writes; read-only and unmapped addresses fall through and are ignored.
	// Reserved bits are dropped on the way in, except in the normal-judgment words, which are stored whole.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			in_cfg_r   <= '0;
			user_out_r <= '0;
			epc_len_r  <= `DIO_EPC_LEN_AUTO;
			irq_mask_r <= '0;
			for (int i = 0; i < NPORT; i++) begin
				out_cfg_r[i] <= '0;
				nrm_cfg_r[i] <= '0;
				err_cfg_r[i] <= '0;
				dur_r[i]     <= '0;
				ref_r[i]     <= '0;
			end
		end else if (wr_en) begin
			case (PADDR)
				`DIO_OFS_IN_CFG:   in_cfg_r   <= PWDATA[NPORT-1:0];
				`DIO_OFS_OUT_USER: user_out_r <= PWDATA[NPORT-1:0];
				`DIO_OFS_IRQ_MASK: irq_mask_r <= PWDATA[`DIO_IRQ_W-1:0];
				`DIO_OFS_EPC_LEN: begin
					// The whole word is compared so that a large value is refused rather than wrapped.
					if (PWDATA <= 32'(`DIO_EPC_LEN_MAX)) begin
						epc_len_r <= PWDATA[5:0];
					end
				end
				`DIO_OFS_OUT_CFG: begin
					for (int i = 0; i < NPORT; i++) begin
						out_cfg_r[i] <= PWDATA[i*`DIO_OCFG_STRIDE +: `DIO_OCFG_W];
					end
				end
				default: begin
					if (in_bank(PADDR, `DIO_OFS_NRM_CFG0)) begin
						nrm_cfg_r[port_idx(PADDR, `DIO_OFS_NRM_CFG0)] <= PWDATA;
					end else if (in_bank(PADDR, `DIO_OFS_ERR_CFG0)) begin
						err_cfg_r[port_idx(PADDR, `DIO_OFS_ERR_CFG0)] <= PWDATA[7:0];
					end else if (in_bank(PADDR, `DIO_OFS_DUR0)) begin
						dur_r[port_idx(PADDR, `DIO_OFS_DUR0)] <= PWDATA[2*DUR_W-1:0];
					end else if (in_bank(PADDR, `DIO_OFS_REF0)) begin
						ref_r[port_idx(PADDR, `DIO_OFS_REF0)] <= PWDATA;
					end
				end
			endcase
		end
	end

	assign EPC_LEN  = epc_len_r;
	// Auto mode is the reset value, so the tag engine detects the length until software fixes one.
	assign EPC_AUTO = (epc_len_r == `DIO_EPC_LEN_AUTO);

	// Per-port judgment timers; the error judgment wins when both could fire on one result.
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_port
			dio_pkg::pulse_st_t st_r;
			logic [DUR_W-1:0]   left_r;
			logic [15:0]        tick_r;
			logic [DUR_W-1:0]   load;

			assign nrm_hit[g] = COMM_RESULT.valid && COMM_RESULT.ok && nrm_cfg_r[g][`DIO_NRM_EN_BIT]
				&& normal_match(nrm_cfg_r[g], ref_r[g], COMM_RESULT);
			assign err_hit[g] = COMM_RESULT.valid && !COMM_RESULT.ok
				&& (COMM_RESULT.err_code == err_cfg_r[g]);
			// A zero duration leaves the line untouched, so a port may judge one condition only.
			assign load = err_hit[g] ? dur_r[g][2*DUR_W-1:DUR_W] : dur_r[g][DUR_W-1:0];

			always_ff @(posedge CLK or posedge SYS_RST) begin
				if (SYS_RST) begin
					st_r   <= dio_pkg::ST_IDLE;
					left_r <= '0;
					tick_r <= '0;
				// A new hit restarts the prescaler too, so a retriggered pulse always lasts its full duration.
				end else if ((nrm_hit[g] || err_hit[g]) && load != '0) begin
					st_r   <= dio_pkg::ST_HOLD;
					left_r <= load;
					tick_r <= '0;
				end else begin
					case (st_r)
						dio_pkg::ST_IDLE: begin
							st_r <= dio_pkg::ST_IDLE;
						end
						dio_pkg::ST_HOLD: begin
							if (tick_r == 16'(DUR_CYC - 1)) begin
								tick_r <= '0;
								if (left_r == DUR_W'(1)) begin
									st_r <= dio_pkg::ST_IDLE;
								end
								left_r <= left_r - DUR_W'(1);
							end else begin
								tick_r <= tick_r + 16'h0001;
							end
						end
						default: st_r <= dio_pkg::ST_IDLE;
					endcase
				end
			end

			// Each port forms both candidate levels; the output stage picks one by mode.
			assign pulse_lvl[g] = (st_r == dio_pkg::ST_HOLD);
			assign stat_lvl[g]  = status_level(out_cfg_r[g][`DIO_OCFG_SEL_MSB:`DIO_OCFG_SEL_LSB], RDR_STATUS);
		end
	endgenerate

	// Output pins come from flip-flops, selected by each port's mode.
	// Reserved mode codes drive low, so a half-written setup never pulses a line.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dout_r <= '0;
		end else begin
			for (int i = 0; i < NPORT; i++) begin
				case (dio_pkg::out_mode_t'(out_cfg_r[i][`DIO_OCFG_MODE_MSB:0]))
					dio_pkg::OUT_USER:   dout_r[i] <= user_out_r[i];
					dio_pkg::OUT_STATUS: dout_r[i] <= stat_lvl[i];
					dio_pkg::OUT_RESULT: dout_r[i] <= pulse_lvl[i];
					default:             dout_r[i] <= 1'b0;
				endcase
			end
		end
	end

	assign DOUT = dout_r;

	assign irq_set = {err_hit, nrm_hit, startup_hit, edge_hit};

	assign rd_stat = rd_en && (PADDR == `DIO_OFS_IRQ_STAT);

	// A read clears only the bits it captured in its setup cycle, so an event that lands
	// between capture and clear stays pending; an event in the clearing cycle still lands.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~(rd_stat ? PRDATA[`DIO_IRQ_W-1:0] : '0)) | irq_set;
		end
	end

	// The interrupt is a level that stays high until every unmasked status bit has been read.
	assign IRQ = |(irq_stat_r & irq_mask_r);

	// Trigger-mode inputs read as zero, since their level only matters as an edge.
	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		case (PADDR)
			`DIO_OFS_IN_CFG:    rd_data[NPORT-1:0] = in_cfg_r;
			`DIO_OFS_IN_LEVEL:  rd_data[NPORT-1:0] = sync2_r & ~in_cfg_r;
			`DIO_OFS_OUT_USER:  rd_data[NPORT-1:0] = user_out_r;
			`DIO_OFS_OUT_LEVEL: rd_data[NPORT-1:0] = dout_r;
			`DIO_OFS_EPC_LEN:   rd_data[5:0] = epc_len_r;
			`DIO_OFS_IRQ_STAT:  rd_data[`DIO_IRQ_W-1:0] = irq_stat_r;
			`DIO_OFS_IRQ_MASK:  rd_data[`DIO_IRQ_W-1:0] = irq_mask_r;
			`DIO_OFS_STATUS_IN: rd_data[7:0] = RDR_STATUS;
			`DIO_OFS_OUT_CFG: begin
				for (int i = 0; i < NPORT; i++) begin
					rd_data[i*`DIO_OCFG_STRIDE +: `DIO_OCFG_W] = out_cfg_r[i];
				end
			end
			default: begin
				if (in_bank(PADDR, `DIO_OFS_NRM_CFG0)) begin
					rd_data = nrm_cfg_r[port_idx(PADDR, `DIO_OFS_NRM_CFG0)];
				end else if (in_bank(PADDR, `DIO_OFS_ERR_CFG0)) begin
					rd_data[7:0] = err_cfg_r[port_idx(PADDR, `DIO_OFS_ERR_CFG0)];
				end else if (in_bank(PADDR, `DIO_OFS_DUR0)) begin
					rd_data[2*DUR_W-1:0] = dur_r[port_idx(PADDR, `DIO_OFS_DUR0)];
				end else if (in_bank(PADDR, `DIO_OFS_REF0)) begin
					rd_data = ref_r[port_idx(PADDR, `DIO_OFS_REF0)];
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	// Read data is registered at the end of the setup cycle so PRDATA stays a flip-flop output.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PRDATA  <= '0;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA  <= rd_data;
		end
	end

	// Unmapped writes are dropped quietly; only a read reports an error, as its data would mean nothing.
	assign PSLVERR = PSEL && PENABLE && !rd_ok && !PWRITE;

endmodule : dio_self_op

// >>> sim/dio_self_op_checker.sv
/* Concurrent checks on the ports of the discrete I/O block.
   Assumes it is bound to every dio_self_op instance. */
module dio_self_op_checker #(
	parameter int NPORT = 4
) (
	// Clock and reset
	input wire logic             CLK,
	input wire logic             SYS_RST,
	// APB
	input wire logic             PSEL,
	input wire logic             PENABLE,
	input wire logic             PWRITE,
	input wire logic [31:0]      PRDATA,
	input wire logic             PREADY,
	input wire logic             PSLVERR,
	// Pins and launches
	input wire logic [NPORT-1:0] DIN,
	input wire logic             HOST_CONNECT,
	input wire logic             RUN_STARTUP,
	input wire logic [NPORT-1:0] RUN_INPUT,
	input wire logic [5:0]       EPC_LEN,
	input wire logic             EPC_AUTO
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	sequence rd_setup;
		PSEL && !PENABLE && !PWRITE;
	endsequence
	sequence conn_rise;
		!HOST_CONNECT ##1 HOST_CONNECT;
	endsequence

	ready_read_a: assert property (rd_setup ##1 (PSEL && PENABLE) |-> PREADY)
		else $error("read access not answered");
	slverr_read_a: assert property (PSLVERR |-> PSEL && PENABLE && !PWRITE && PRDATA == 32'h0)
		else $error("error response outside an unmapped read");
	data_hold_a: assert property ($changed(PRDATA) |-> $past(PSEL && !PENABLE && !PWRITE))
		else $error("read data changed outside a read setup");
	epc_auto_a: assert property (EPC_AUTO == (EPC_LEN == 6'h00))
		else $error("auto length flag disagrees with length");
	epc_range_a: assert property (EPC_LEN <= 6'h20)
		else $error("length above thirty-two words");
	conn_start_a: assert property (conn_rise |=> RUN_STARTUP)
		else $error("connection did not launch the startup series");
	start_pulse_a: assert property (RUN_STARTUP |=> !RUN_STARTUP)
		else $error("startup launch longer than one cycle");
	trig_pulse_a: assert property (RUN_INPUT != '0 |=> (RUN_INPUT & $past(RUN_INPUT)) == '0)
		else $error("input launch longer than one cycle");
	trig_cause_a: assert property (RUN_INPUT != '0 |->
		(RUN_INPUT & ~($past(DIN, 2) & $past(DIN, 3) & ~$past(DIN, 4))) == '0)
		else $error("input launch without a preceding rise");
endmodule : dio_self_op_checker

bind dio_self_op dio_self_op_checker #(.NPORT(NPORT)) i_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DIN(DIN),
	.HOST_CONNECT(HOST_CONNECT), .RUN_STARTUP(RUN_STARTUP), .RUN_INPUT(RUN_INPUT), .EPC_LEN(EPC_LEN),
	.EPC_AUTO(EPC_AUTO));

// >>> sim/dio_machine_model.sv
/* Machine-side model of the discrete lines feeding the four block inputs.
   Assumes the bench calls its tasks right after a rising clock edge. */
module dio_machine_model (
	// Clock
	input wire logic clk,
	// Lines toward the block
	output logic [3:0] din
);
	timeunit 1ns;
	timeprecision 1ns;
	initial din = 4'h0;

	task automatic set_level(input logic [3:0] v);
		din <= v;
	endtask : set_level

	// Four cycles each way keeps every level above the synchroniser's minimum width.
	task automatic strike(input logic [3:0] m);
		din <= m;
		repeat (4) @(posedge clk);
		din <= 4'h0;
		repeat (4) @(posedge clk);
	endtask : strike
endmodule : dio_machine_model

// >>> sim/tb_top.sv
/* Self-checking bench of the discrete I/O block with a machine-side line model.
   Assumes the checker is bound and the design defaults NPORT to four. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, sys_rst, psel, penable, pwrite, host_connect, slverr, pready, pslverr;
	logic run_startup, epc_auto, irq, ok, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, r, d;
	logic [3:0] din, dout, run_input, v;
	logic [5:0] epc_len;
	logic [15:0] c, t;
	logic [7:0] code, ec;
	logic [2:0] op;
	dio_pkg::reader_status_t rdr;
	dio_pkg::comm_result_t comm;
	int err_count, num_checks, n_start;
	int n_trig[4];

	dio_self_op i_dio_self_op (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DIN(din),
		.DOUT(dout), .RDR_STATUS(rdr), .COMM_RESULT(comm), .HOST_CONNECT(host_connect),
		.RUN_STARTUP(run_startup), .RUN_INPUT(run_input), .EPC_LEN(epc_len), .EPC_AUTO(epc_auto), .IRQ(irq));
	dio_machine_model i_dio_machine_model (.clk(clk), .din(din));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		n_start += (run_startup === 1'b1);
		for (int i = 0; i < 4; i++) n_trig[i] += (run_input[i] === 1'b1);
	end

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rc(input string n, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(n, q, exp);
	endtask : rc

	function automatic logic hit(input logic [2:0] o, input logic [15:0] cc, input logic [15:0] tc,
		input logic [31:0] rf, input logic [31:0] dd);
		case (o)
			3'h0: return tc >= cc;
			3'h1: return tc <= cc;
			3'h2: return tc == cc;
			3'h3: return tc != cc;
			3'h4: return dd == rf;
			default: return dd != rf;
		endcase
	endfunction : hit

	task automatic complete_run();
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		complete_run();
	end

	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, host_connect} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rdr = '0;
		comm = '0;
		void'($urandom(35));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("power_up", n_start, 1);
		v = 4'($urandom);
		i_dio_machine_model.set_level(v);
		repeat (4) @(posedge clk);
		rc("in_level", 12'h004, {28'h0, v});
		apb(1'b1, 12'h000, 32'hA);
		rc("in_level_trg", 12'h004, {28'h0, v & 4'h5});
		i_dio_machine_model.set_level(4'h0);
		repeat (4) @(posedge clk);
		rc("irq_boot", 12'h0A4, 32'h10);
		apb(1'b1, 12'h0A8, 32'h2);
		repeat (2) i_dio_machine_model.strike(4'hF);
		for (int i = 0; i < 4; i++) chk("trig_count", n_trig[i], (i % 2) ? 2 : 0);
		chk("irq_set", irq, 1);
		rc("irq_stat", 12'h0A4, 32'hA);
		chk("irq_clear", irq, 0);
		apb(1'b1, 12'h0A8, 32'h0);
		i_dio_machine_model.strike(4'h8);
		chk("irq_masked", irq, 0);
		rc("irq_stat_m", 12'h0A4, 32'h8);
		// The startup launch is only counted here; no reset of the block is issued with it.
		host_connect <= 1'b1;
		repeat (3) @(posedge clk);
		chk("connect", n_start, 2);
		apb(1'b1, 12'h008, 32'h0);
		v = 4'($urandom);
		apb(1'b1, 12'h00C, {28'h0, v});
		// DOUT is registered, so it follows a write one edge after the access completes.
		@(posedge clk);
		chk("dout_user", dout, v);
		rc("out_level", 12'h0AC, {28'h0, v});
		for (int s = 0; s < 8; s++) begin
			if (s == 3) continue;
			rdr <= 8'($urandom);
			apb(1'b1, 12'h008, {4{3'h0, 3'(s), 2'h1}});
			e = s == 0 ? rdr.running : s == 1 ? rdr.fault : s == 2 ? |rdr.ant_active : rdr.ant_sel == 2'(s - 4);
			@(posedge clk);
			chk("dout_stat", dout, {4{e}});
		end
		apb(1'b1, 12'h008, 32'h02020202);
		apb(1'b1, 12'h060, 32'h00010001);
		for (int k = 0; k < 10; k++) begin
			op = 3'(k % 6);
			c = 16'($urandom);
			r = $urandom;
			code = 8'($urandom);
			ok = k < 8;
			t = c + 16'($urandom % 3) - 16'h1;
			d = ($urandom % 2) ? r : $urandom;
			ec = (k == 9) ? code + 8'h1 : code;
			apb(1'b1, 12'h020, {c, 12'h0, 1'b1, op});
			apb(1'b1, 12'h040, {24'h0, code});
			apb(1'b1, 12'h080, r);
			comm <= '{1'b1, ok, t, d, ec};
			@(posedge clk);
			comm.valid <= 1'b0;
			e = ok ? hit(op, c, t, r, d) : ec == code;
			repeat (3) @(posedge clk);
			chk("judge", dout[0], e);
			if (e) begin
				repeat (990) @(posedge clk);
				chk("hold", dout[0], 1);
				repeat (20) @(posedge clk);
				chk("release", dout[0], 0);
			end
		end
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h0A0, i == 4 ? 32'h41 : i == 3 ? 32'h21 : i == 2 ? 32'h20 : 32'(i));
			chk("epc_len", epc_len, i < 2 ? 32'(i) : 32'h20);
			chk("epc_auto", epc_auto, i == 0);
		end
		apb(1'b0, 12'hFF0, 32'h0);
		chk("slverr", slverr, 1);
		chk("unmapped", q, 0);
		complete_run();
	end
endmodule : tb_top
